// ---- rtl/serial_lane_status_flags.sv ----
// read-only lane status flags of the serial receive port, paged per link
// assumes decoder reports arrive on clk_i, one bit per lane, per link
//
// Function
// - each lane flags when its invalid-symbol count reaches the threshold
// - register 0x46F holds one unexpected control-character flag per lane
// - flag reads 0 below threshold, 1 at or above it
// - link page field in register 0x300 selects the reported link
// - register 0x470 holds per-lane code group lock, 1 when locked
// - all lane flags read-only and zero after reset
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "lane_status_consts.svh"

module serial_lane_status_flags (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire lane_status_pkg::lane_rx_type [1:0] lane_rx_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o
);

  // ==========================================================
  // helpers
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
    addr_hit = (addr == offset);
  endfunction

  function automatic logic any_rise(input logic [7:0] now, input logic [7:0] prev);
    any_rise = |(now & ~prev);
  endfunction

  // ==========================================================
  // request decode
  lane_status_pkg::reg_req_type req;
  logic wr_page;
  logic wr_thresh;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_count_ctrl;

  always_comb begin
    req.addr = reg_addr_i;
    req.wdata = reg_wdata_i;
    req.wr = reg_wr_i;
    req.rd = reg_rd_i;
    wr_page = req.wr && addr_hit(req.addr, `LS_ADDR_LINK_PAGE);
    wr_thresh = req.wr && addr_hit(req.addr, `LS_ADDR_THRESHOLD);
    wr_irq_status = req.wr && addr_hit(req.addr, `LS_ADDR_IRQ_STATUS);
    wr_irq_mask = req.wr && addr_hit(req.addr, `LS_ADDR_IRQ_MASK);
    wr_count_ctrl = req.wr && addr_hit(req.addr, `LS_ADDR_COUNT_CTRL);
  end

  // ==========================================================
  // control registers
  logic link_page_q;
  logic link_page_d;
  logic [7:0] error_count_threshold_q;
  logic [7:0] error_count_threshold_d;
  logic count_clear_q;
  logic count_clear_d;

  always_comb begin
    link_page_d = link_page_q;
    error_count_threshold_d = error_count_threshold_q;
    if (wr_page) begin
      link_page_d = req.wdata[`LS_LINK_PAGE_BIT];
    end
    if (wr_thresh) begin
      error_count_threshold_d = req.wdata;
    end
    count_clear_d = wr_count_ctrl && req.wdata[`LS_COUNT_CLEAR_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      link_page_q <= `LS_RST_LINK_PAGE;
      error_count_threshold_q <= `LS_RST_THRESHOLD;
      count_clear_q <= 1'b0;
    end else begin
      link_page_q <= link_page_d;
      error_count_threshold_q <= error_count_threshold_d;
      count_clear_q <= count_clear_d;
    end
  end

  // ==========================================================
  // per-lane error counters
  lane_status_pkg::lane_flags_type [1:0] err_flags;

  for (genvar link = 0; link < 2; link++) begin : g_link
    for (genvar lane = 0; lane < 8; lane++) begin : g_lane
      lane_err_counter u_invalid (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .err_i(lane_rx_i[link].invalid_symbol[lane]),
        .clr_i(count_clear_q),
        .thresh_i(error_count_threshold_q),
        .flag_o(err_flags[link].invalid_symbol[lane])
      );
      lane_err_counter u_unexp (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .err_i(lane_rx_i[link].unexpected_ctrl[lane]),
        .clr_i(count_clear_q),
        .thresh_i(error_count_threshold_q),
        .flag_o(err_flags[link].unexpected_ctrl[lane])
      );
    end
  end

  // ==========================================================
  // code group lock capture
  logic [1:0][7:0] cgs_q;
  logic [1:0][7:0] cgs_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cgs_d[i] = lane_rx_i[i].code_group_locked;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cgs_q <= {2{`LS_RST_FLAGS}};
    end else begin
      cgs_q <= cgs_d;
    end
  end

  // ==========================================================
  // interrupt events
  lane_status_pkg::lane_flags_type [1:0] flags_prev_q;
  lane_status_pkg::lane_flags_type [1:0] flags_prev_d;
  logic [1:0][7:0] cgs_prev_q;
  logic [1:0][7:0] cgs_prev_d;
  logic [2:0] events;

  always_comb begin
    flags_prev_d = err_flags;
    cgs_prev_d = cgs_q;
    events = 3'h0;
    for (int i = 0; i < 2; i++) begin
      events[`LS_IRQ_INVALID_BIT] = events[`LS_IRQ_INVALID_BIT]
        | any_rise(err_flags[i].invalid_symbol, flags_prev_q[i].invalid_symbol);
      events[`LS_IRQ_UNEXP_BIT] = events[`LS_IRQ_UNEXP_BIT]
        | any_rise(err_flags[i].unexpected_ctrl, flags_prev_q[i].unexpected_ctrl);
      events[`LS_IRQ_SYNC_LOST_BIT] = events[`LS_IRQ_SYNC_LOST_BIT]
        | any_rise(cgs_prev_q[i], cgs_q[i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_prev_q <= '0;
      cgs_prev_q <= '0;
    end else begin
      flags_prev_q <= flags_prev_d;
      cgs_prev_q <= cgs_prev_d;
    end
  end

  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic irq_line;

  lane_irq_bank u_irq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .event_i(events),
    .clr_wr_i(wr_irq_status),
    .mask_wr_i(wr_irq_mask),
    .wdata_i(req.wdata[2:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_line)
  );

  // ==========================================================
  // read path, data one cycle after the strobe
  lane_status_pkg::lane_flags_type page_flags;
  logic [7:0] page_cgs;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    // link page picks the reported link
    page_flags = err_flags[link_page_q];
    page_cgs = cgs_q[link_page_q];
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `LS_ADDR_LINK_PAGE: begin
          rdata_d = {7'h00, link_page_q};
        end
        // lane 0 invalid symbol flag in bit 0
        `LS_ADDR_INVALID_SYM: begin
          rdata_d = page_flags.invalid_symbol;
        end
        `LS_ADDR_UNEXP_CTRL: begin
          rdata_d = page_flags.unexpected_ctrl;
        end
        // lock flags, bit n is lane n
        `LS_ADDR_CGS_LOCK: begin
          rdata_d = page_cgs;
        end
        `LS_ADDR_THRESHOLD: begin
          rdata_d = error_count_threshold_q;
        end
        `LS_ADDR_IRQ_STATUS: begin
          rdata_d = {5'h00, irq_status};
        end
        `LS_ADDR_IRQ_MASK: begin
          rdata_d = {5'h00, irq_mask};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_line;

endmodule // serial_lane_status_flags

// ---- common/lane_status_consts.svh ----
// offsets, field positions, reset values for the lane status register bank
// assumes an 8-bit register port with a 12-bit address
`ifndef LANE_STATUS_CONSTS_SVH
`define LANE_STATUS_CONSTS_SVH

// ==========================================================
// register offsets
`define LS_ADDR_LINK_PAGE      12'h300
`define LS_ADDR_INVALID_SYM    12'h46E
`define LS_ADDR_UNEXP_CTRL     12'h46F
`define LS_ADDR_CGS_LOCK       12'h470
`define LS_ADDR_THRESHOLD      12'h478
`define LS_ADDR_IRQ_STATUS     12'h479
`define LS_ADDR_IRQ_MASK       12'h47A
`define LS_ADDR_COUNT_CTRL     12'h47B

// ==========================================================
// field positions
`define LS_LINK_PAGE_BIT       0
`define LS_COUNT_CLEAR_BIT     0
`define LS_IRQ_INVALID_BIT     0
`define LS_IRQ_UNEXP_BIT       1
`define LS_IRQ_SYNC_LOST_BIT   2

// ==========================================================
// reset values
`define LS_RST_FLAGS           8'h00
`define LS_RST_THRESHOLD       8'hFF
`define LS_RST_LINK_PAGE       1'h0
`define LS_RST_IRQ_MASK        3'h0
`define LS_RST_COUNT           8'h00
`define LS_COUNT_MAX           8'hFF

`endif

// ---- common/lane_status_pkg.sv ----
// types shared by the lane status register bank
// assumes eight lanes per link and two links
package lane_status_pkg;

  // ==========================================================
  // per-link decoder reports, same clock as the bank
  typedef struct packed {
    logic [7:0] invalid_symbol;
    logic [7:0] unexpected_ctrl;
    logic [7:0] code_group_locked;
  } lane_rx_type;

  // ==========================================================
  // per-link threshold flags
  typedef struct packed {
    logic [7:0] invalid_symbol;
    logic [7:0] unexpected_ctrl;
  } lane_flags_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

endpackage

// ---- rtl/lane_err_counter.sv ----
// saturating error counter with threshold flag for one lane and error type
// assumes err_i and thresh_i come from logic on clk_i
`timescale 1ns/10ps
`include "lane_status_consts.svh"

module lane_err_counter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic err_i,
  input wire logic clr_i,
  input wire logic [7:0] thresh_i,
  output logic flag_o
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic flag_q;
  logic flag_d;

  always_comb begin
    count_d = count_q;
    if (clr_i) begin
      count_d = `LS_RST_COUNT;
    end else if (err_i && (count_q != `LS_COUNT_MAX)) begin
      count_d = count_q + 8'h01;
    end
    flag_d = (count_q >= thresh_i);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= `LS_RST_COUNT;
      flag_q <= 1'b0;
    end else begin
      count_q <= count_d;
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule // lane_err_counter

// ---- rtl/lane_irq_bank.sv ----
// sticky event status, write-one-to-clear, mask and level interrupt
// assumes events are one-cycle pulses on clk_i
`timescale 1ns/10ps
`include "lane_status_consts.svh"

module lane_irq_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] event_i,
  input wire logic clr_wr_i,
  input wire logic mask_wr_i,
  input wire logic [2:0] wdata_i,
  output logic [2:0] status_o,
  output logic [2:0] mask_o,
  output logic irq_o
);

  logic [2:0] status_q;
  logic [2:0] status_d;
  logic [2:0] mask_q;
  logic [2:0] mask_d;
  logic irq_q;
  logic irq_d;

  always_comb begin
    status_d = status_q;
    if (clr_wr_i) begin
      status_d = status_q & ~wdata_i;
    end
    // set beats a clear in the same cycle
    status_d = status_d | event_i;
    mask_d = mask_wr_i ? wdata_i : mask_q;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= 3'h0;
      mask_q <= `LS_RST_IRQ_MASK;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = irq_q;

endmodule // lane_irq_bank

// ---- dv/serial_lane_status_flags_monitor.sv ----
// checker on the lane status bank ports
// assumes binding onto serial_lane_status_flags, one clock
`timescale 1ns/10ps
`include "lane_status_consts.svh"

module serial_lane_status_flags_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire lane_status_pkg::lane_rx_type [1:0] lane_rx_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic irq_o
);
  logic pg_q;
  logic [7:0] thr_q;
  logic [2:0] msk_q;
  logic [7:0] lk;
  lane_status_pkg::lane_rx_type [1:0] rx_q;
  logic known;
  // ====
  // shadow of writable fields
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pg_q <= 1'h0;
      thr_q <= 8'hFF;
      msk_q <= 3'h0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `LS_ADDR_LINK_PAGE) pg_q <= reg_wdata_i[0];
      if (reg_addr_i == `LS_ADDR_THRESHOLD) thr_q <= reg_wdata_i;
      if (reg_addr_i == `LS_ADDR_IRQ_MASK) msk_q <= reg_wdata_i[2:0];
    end
  end
  // lock reports as the bank registers them, one edge late
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_q <= '0;
    end else begin
      rx_q <= lane_rx_i;
    end
  end
  assign lk = rx_q[pg_q].code_group_locked;
  assign known = reg_addr_i inside {`LS_ADDR_LINK_PAGE, `LS_ADDR_INVALID_SYM,
    `LS_ADDR_UNEXP_CTRL, `LS_ADDR_CGS_LOCK, `LS_ADDR_THRESHOLD, `LS_ADDR_IRQ_STATUS,
    `LS_ADDR_IRQ_MASK, `LS_ADDR_COUNT_CTRL};
  // ====
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_quiet_a: assert property (
    $rose(rst_n_i) |-> reg_rdata_o == 8'h00 && !irq_o) else $error("outputs not quiet");
  rdata_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data without read");
  unmapped_zero_a: assert property (
    reg_rd_i && !known |=> reg_rdata_o == 8'h00) else $error("unmapped read not 0");
  page_read_a: assert property (
    reg_rd_i && reg_addr_i == `LS_ADDR_LINK_PAGE |=> reg_rdata_o == {7'h00, pg_q})
    else $error("link page readback");
  thresh_read_a: assert property (
    reg_rd_i && reg_addr_i == `LS_ADDR_THRESHOLD |=> reg_rdata_o == thr_q)
    else $error("threshold readback");
  mask_read_a: assert property (
    reg_rd_i && reg_addr_i == `LS_ADDR_IRQ_MASK |=> reg_rdata_o == {5'h00, msk_q})
    else $error("mask readback");
  lock_read_a: assert property (
    reg_rd_i && reg_addr_i == `LS_ADDR_CGS_LOCK |=> reg_rdata_o == $past(lk))
    else $error("lock flags wrong");
  zero_thresh_a: assert property (
    reg_rd_i && reg_addr_i == `LS_ADDR_UNEXP_CTRL && thr_q == 8'h00 && $stable(thr_q)
    |=> reg_rdata_o == 8'hFF) else $error("zero threshold flags");
  mask_off_a: assert property (
    reg_wr_i && reg_addr_i == `LS_ADDR_IRQ_MASK && reg_wdata_i[2:0] == 3'h0
    |=> !irq_o) else $error("irq with mask clear");
endmodule // serial_lane_status_flags_monitor

// ---- dv/lane_tx_model.sv ----
// far-side lane transmitter: error pulses and lock levels
// assumes the bench calls its tasks, one link at a time
`timescale 1ns/10ps

module lane_tx_model (
  input wire logic clk_i,
  output lane_status_pkg::lane_rx_type [1:0] lane_rx_o
);
  initial lane_rx_o = '0;
  // ====
  // n back-to-back error pulses on chosen lanes
  task automatic burst(input int lk, input bit ctl, input logic [7:0] ln, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (ctl) lane_rx_o[lk].unexpected_ctrl <= ln;
      else lane_rx_o[lk].invalid_symbol <= ln;
    end
    @(posedge clk_i);
    lane_rx_o[lk].unexpected_ctrl <= 8'h00;
    lane_rx_o[lk].invalid_symbol <= 8'h00;
  endtask
  task automatic lock(input int lk, input logic [7:0] v);
    @(posedge clk_i);
    lane_rx_o[lk].code_group_locked <= v;
  endtask
endmodule // lane_tx_model

// ---- dv/serial_lane_status_flags_test.sv ----
// self-checking bench for the lane status bank
// assumes lane_tx_model as far side, checker bound below
`timescale 1ns/10ps
`include "lane_status_consts.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end

module serial_lane_status_flags_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  lane_status_pkg::lane_rx_type [1:0] lane_rx;
  logic [7:0] reg_rdata_o;
  logic irq_o;
  logic pend = 1'b0;
  logic [7:0] q[$];
  logic [7:0] ex, t, m, r;
  logic [31:0] seed = 32'h04FD;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;

  always #20 clk_i = ~clk_i;
  serial_lane_status_flags dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .lane_rx_i(lane_rx), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  lane_tx_model tx (.clk_i(clk_i), .lane_rx_o(lane_rx));
  // ====
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    q.push_back(e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge clk_i);
    `CHK("irq", e, irq_o)
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // read data compare, oldest note first
  always @(posedge clk_i) pend <= reg_rd_i;
  always @(negedge clk_i) begin
    if (pend) begin
      ex = q.pop_front();
      `CHK("read data", ex, reg_rdata_o)
    end
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end
  // ====
  // scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`LS_ADDR_INVALID_SYM, 8'h00);
    rd(`LS_ADDR_CGS_LOCK, 8'h00);
    rd(`LS_ADDR_THRESHOLD, 8'hFF);
    rd(12'h123, 8'h00);
    wr(`LS_ADDR_UNEXP_CTRL, 8'hFF);
    rd(`LS_ADDR_UNEXP_CTRL, 8'h00);
    seed = xs(seed);
    t = {5'h00, seed[2:0]} + 8'h02;
    m = {1'b0, seed[14:9], 1'b1};
    wr(`LS_ADDR_THRESHOLD, t);
    tx.burst(0, 1'b1, m, t - 1);
    rd(`LS_ADDR_UNEXP_CTRL, 8'h00);
    tx.burst(0, 1'b1, m, 1);
    rd(`LS_ADDR_UNEXP_CTRL, m);
    tx.burst(0, 1'b0, 8'h01, t);
    rd(`LS_ADDR_INVALID_SYM, 8'h01);
    rd(`LS_ADDR_UNEXP_CTRL, m);
    wr(`LS_ADDR_LINK_PAGE, 8'h01);
    rd(`LS_ADDR_LINK_PAGE, 8'h01);
    rd(`LS_ADDR_UNEXP_CTRL, 8'h00);
    tx.burst(1, 1'b1, ~m, t);
    rd(`LS_ADDR_UNEXP_CTRL, ~m);
    wr(`LS_ADDR_LINK_PAGE, 8'h00);
    rd(`LS_ADDR_UNEXP_CTRL, m);
    seed = xs(seed);
    r = {1'b1, seed[6:1], 1'b0};
    tx.lock(0, r);
    tx.lock(1, ~r);
    rd(`LS_ADDR_CGS_LOCK, r);
    wr(`LS_ADDR_LINK_PAGE, 8'h01);
    rd(`LS_ADDR_CGS_LOCK, ~r);
    wr(`LS_ADDR_IRQ_MASK, 8'h07);
    rd(`LS_ADDR_IRQ_STATUS, 8'h03);
    rd(`LS_ADDR_IRQ_MASK, 8'h07);
    chk_irq(1'b1);
    wr(`LS_ADDR_IRQ_STATUS, 8'h07);
    rd(`LS_ADDR_IRQ_STATUS, 8'h00);
    chk_irq(1'b0);
    tx.lock(1, 8'h00);
    // lock fall takes two edges to reach the sticky status
    @(posedge clk_i);
    rd(`LS_ADDR_IRQ_STATUS, 8'h04);
    chk_irq(1'b1);
    wr(`LS_ADDR_IRQ_MASK, 8'h00);
    chk_irq(1'b0);
    wr(`LS_ADDR_LINK_PAGE, 8'h00);
    wr(`LS_ADDR_COUNT_CTRL, 8'h01);
    rd(`LS_ADDR_COUNT_CTRL, 8'h00);
    rd(`LS_ADDR_UNEXP_CTRL, 8'h00);
    wr(`LS_ADDR_THRESHOLD, 8'h00);
    rd(`LS_ADDR_THRESHOLD, 8'h00);
    rd(`LS_ADDR_INVALID_SYM, 8'hFF);
    rd(`LS_ADDR_UNEXP_CTRL, 8'hFF);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`LS_ADDR_INVALID_SYM, 8'h00);
    rd(`LS_ADDR_THRESHOLD, 8'hFF);
    repeat (2) @(negedge clk_i);
    report_and_stop;
  end
endmodule // serial_lane_status_flags_test

bind serial_lane_status_flags serial_lane_status_flags_monitor mon (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .lane_rx_i(lane_rx_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
